//--- logic/ccw_top.sv
`timescale 1ns/100ps
`default_nettype none
module ccw_top (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_byte_wr,
    input  wire logic       sfr_bit_wr,
    input  wire logic       sfr_bit_val,
    input  wire logic       sfr_rd,
    input  wire logic       instr_end,
    input  wire logic       crystal_in_pin,
    input  wire logic       flash_wdt_prot_bit,
    output logic [7:0]      sfr_rdata,
    output logic            sys_reset_req,
    output logic            download_reset_req,
    output logic            wdt_irq
);
    ccw_pkg::ccw_unlock_t state_reg;
    logic [3:0]           prescale_reg;
    logic                 resp_reg;
    logic                 en_reg;
    logic                 flag_reg;
    logic                 clear_pending_reg;
    logic                 sys_reset_reg;
    logic                 dl_reset_reg;
    logic                 irq_reg;
    logic [7:0]           rdata_reg;

    logic                 prot_on;
    logic                 resp_eff;
    logic                 en_eff;
    logic                 hit_byte;
    logic                 hit_bit;
    logic                 wr_hit;
    logic [7:0]           image;
    logic [7:0]           wr_val;
    logic                 arming;
    logic                 apply;
    logic                 kick;
    logic                 flag_clr;
    logic                 tick;
    logic                 expire;
    logic                 expire_reset;
    logic                 expire_irq;
    logic                 imm_auto;
    logic                 imm_dl;
    logic                 wd_reset_evt;
    ccw_pkg::ccw_ctrl_t   ctrl;

    // ==========================================================
    // Protection and effective settings
    assign prot_on  = ~flash_wdt_prot_bit;
    assign resp_eff = resp_reg & ~prot_on;
    assign en_eff   = en_reg | prot_on;

    assign image = {prescale_reg, resp_eff, flag_reg, en_eff, 1'b0};

    // ==========================================================
    // Byte and bit write decode
    assign hit_byte = sfr_byte_wr && (sfr_addr == ccw_pkg::CTRL_ADDR);
    assign hit_bit  = sfr_bit_wr && (sfr_addr[7:3] == ccw_pkg::CTRL_ADDR[7:3]);
    assign wr_hit   = hit_byte | hit_bit;

    always_comb begin
        wr_val = image;
        if (hit_byte) begin
            wr_val = sfr_wdata;
        end else if (hit_bit) begin
            wr_val[sfr_addr[2:0]] = sfr_bit_val;
        end
    end

    // ==========================================================
    // Unlock sequence
    assign arming = wr_hit && (state_reg == ccw_pkg::CCW_IDLE) && wr_val[ccw_pkg::UNLOCK_BIT];
    assign apply  = wr_hit && (state_reg == ccw_pkg::CCW_ARMED);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ccw_pkg::CCW_IDLE;
        end else begin
            case (state_reg)
                ccw_pkg::CCW_IDLE: begin
                    if (arming && instr_end) begin
                        state_reg <= ccw_pkg::CCW_ARMED;
                    end else if (arming) begin
                        state_reg <= ccw_pkg::CCW_ARMING;
                    end
                end
                ccw_pkg::CCW_ARMING: begin
                    if (instr_end) begin
                        state_reg <= ccw_pkg::CCW_ARMED;
                    end
                end
                ccw_pkg::CCW_ARMED: begin
                    if (apply || instr_end) begin
                        state_reg <= ccw_pkg::CCW_IDLE;
                    end
                end
                default: begin
                    state_reg <= ccw_pkg::CCW_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Write effects
    assign kick     = apply && (hit_byte ? sfr_wdata[ccw_pkg::EN_BIT]
                                         : (sfr_addr[2:0] == 3'h1) && sfr_bit_val);
    assign flag_clr = apply && !wr_val[ccw_pkg::FLAG_BIT]
                      && (hit_byte || sfr_addr[2:0] == 3'h2);
    assign imm_auto = apply && wr_val[ccw_pkg::PRE_MSB:ccw_pkg::PRE_LSB] == ccw_pkg::PRE_AUTO_RESET;
    assign imm_dl   = apply && wr_val[ccw_pkg::PRE_MSB:ccw_pkg::PRE_LSB] == ccw_pkg::PRE_DL_RESET;

    assign expire_reset = expire && !resp_eff;
    assign expire_irq   = expire && resp_eff;
    assign wd_reset_evt = expire_reset | imm_auto | imm_dl;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_reg <= ccw_pkg::PRE_RST;
        end else if (wd_reset_evt) begin
            prescale_reg <= ccw_pkg::PRE_RST;
        end else if (apply) begin
            prescale_reg <= wr_val[ccw_pkg::PRE_MSB:ccw_pkg::PRE_LSB];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp_reg <= ccw_pkg::RESP_RST;
        end else if (wd_reset_evt) begin
            resp_reg <= ccw_pkg::RESP_RST;
        end else if (apply && !prot_on) begin
            resp_reg <= wr_val[ccw_pkg::RESP_BIT];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_reg <= ccw_pkg::EN_RST;
        end else if (wd_reset_evt) begin
            en_reg <= ccw_pkg::EN_RST;
        end else if (apply && !prot_on) begin
            en_reg <= wr_val[ccw_pkg::EN_BIT];
        end
    end

    // Set wins over a software clear; a watchdog reset sets it and never clears it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= ccw_pkg::FLAG_RST;
        end else if (expire || imm_auto || imm_dl) begin
            flag_reg <= 1'b1;
        end else if (flag_clr) begin
            flag_reg <= 1'b0;
        end
    end

    // Held until the next crystal edge takes it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clear_pending_reg <= 1'b0;
        end else if (kick || wd_reset_evt) begin
            clear_pending_reg <= 1'b1;
        end else if (tick) begin
            clear_pending_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Counter
    assign ctrl.prescale = prescale_reg;
    assign ctrl.enable   = en_eff;

    ccw_tick u_tick (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .xtal_level (crystal_in_pin),
        .tick       (tick)
    );

    ccw_counter #(
        .WIDTH (ccw_pkg::CNT_W)
    ) u_counter (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .tick      (tick),
        .clear_req (clear_pending_reg),
        .ctrl      (ctrl),
        .expire    (expire)
    );

    // ==========================================================
    // Responses
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sys_reset_reg <= 1'b0;
        end else begin
            sys_reset_reg <= expire_reset | imm_auto;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dl_reset_reg <= 1'b0;
        end else begin
            dl_reset_reg <= imm_dl;
        end
    end

    // Goes straight to the high priority level, bypassing global_irq_enable
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= expire_irq;
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (sfr_rd && sfr_addr == ccw_pkg::CTRL_ADDR) begin
            rdata_reg <= image;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign sfr_rdata          = rdata_reg;
    assign sys_reset_req      = sys_reset_reg;
    assign download_reset_req = dl_reset_reg;
    assign wdt_irq            = irq_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_FLAG_ON_EXPIRY: assert property (expire |=> flag_reg)
        else $error("timeout flag not set on expiry");
    AST_RESET_MODE: assert property (expire && !resp_eff |=> sys_reset_req && !wdt_irq)
        else $error("reset mode expiry gave no system reset");
    AST_IRQ_MODE: assert property (expire && resp_eff |=> wdt_irq && !sys_reset_req)
        else $error("interrupt mode expiry gave no interrupt");
    AST_LOCKED_WRITE: assert property (!apply && !wd_reset_evt
        |=> $stable(prescale_reg) && $stable(en_reg) && $stable(resp_reg))
        else $error("settings changed without unlock");
    AST_PROTECT_FORCE: assert property (prot_on |-> en_eff && !resp_eff)
        else $error("protection did not force enable and response");
    AST_PRESCALE_UNDER_PROT: assert property (apply && hit_byte && prot_on && !wd_reset_evt
        |=> prescale_reg == $past(sfr_wdata[7:4]) && $stable(en_reg) && $stable(resp_reg))
        else $error("prescale write under protection mishandled");
    AST_IMM_RESET: assert property (imm_auto |=> sys_reset_req ##1 !sys_reset_req)
        else $error("code 8 gave no single reset pulse");
    AST_FLAG_HOLD: assert property (flag_reg && !flag_clr |=> flag_reg)
        else $error("timeout flag dropped without clear");
    AST_KICK_CLEAR: assert property (kick |=> clear_pending_reg)
        else $error("kick did not request counter clear");
    AST_UNLOCK_EXPIRES: assert property (state_reg == ccw_pkg::CCW_ARMED && instr_end
        |=> state_reg == ccw_pkg::CCW_IDLE)
        else $error("unlock window outlived one instruction");

    COV_APPLY: cover property (apply && hit_byte);
    COV_EXPIRE_RESET: cover property (expire_reset);
    COV_EXPIRE_IRQ: cover property (expire_irq ##1 wdt_irq);
    COV_DL_RESET: cover property (imm_dl);
endmodule
`default_nettype wire

//--- include/ccw_pkg.sv
// How it works
// - Out of reset the watchdog runs, two second timeout, resetting the system on expiry.
// - Clearing enable_and_kick at bit 1 of the control register stops the watchdog.
// - No kick within the prescaled timeout gives reset or interrupt and sets timeout_flag.
// - The counter advances only on crystal clock edges, not on the processor clock.
// - Control register writes are ignored unless preceded by the unlock sequence.
// - Set write_unlock, then the very next instruction must write the register.
// - Protection locks enable and response_select; the prescale field stays writable.
// - Protection active while the flash bit is clear; it forces response 0, enable 1.
// - A 16-bit counter; timeout is 2^prescale times 2^9 crystal periods.
// - Codes 0 to 7 double the timeout from 15.6 ms to 2 s; default 7.
// - Code 8 resets at once, code 9 resets into download, 10 to 15 invalid.
// - response_select clear resets the system on expiry; set raises an interrupt.
// - timeout_flag stays set until software writes 0 or a hardware reset occurs.
// - A watchdog reset leaves timeout_flag set.
// - Each write setting enable_and_kick enables the watchdog and restarts the count.
// - The watchdog interrupt is high priority and not masked by global_irq_enable.
package ccw_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] CTRL_ADDR    = 8'hc0;
    localparam int         UNLOCK_BIT   = 0;
    localparam int         EN_BIT       = 1;
    localparam int         FLAG_BIT     = 2;
    localparam int         RESP_BIT     = 3;
    localparam int         PRE_LSB      = 4;
    localparam int         PRE_MSB      = 7;
    // ==========================================================
    // Reset values
    localparam logic [3:0] PRE_RST      = 4'h7;
    localparam logic       EN_RST       = 1'b1;
    localparam logic       RESP_RST     = 1'b0;
    localparam logic       FLAG_RST     = 1'b0;
    // ==========================================================
    // Prescale codes and counter timing
    localparam logic [3:0] PRE_MAX_TIMED  = 4'h7;
    localparam logic [3:0] PRE_AUTO_RESET = 4'h8;
    localparam logic [3:0] PRE_DL_RESET   = 4'h9;
    localparam int         CNT_W          = 16;
    localparam int         CNT_BASE_EXP   = 9;
    localparam int         XTAL_HZ        = 32768;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CCW_IDLE,
        CCW_ARMING,
        CCW_ARMED
    } ccw_unlock_t;

    typedef struct packed {
        logic [3:0] prescale;
        logic       enable;
    } ccw_ctrl_t;
endpackage

//--- logic/ccw_tick.sv
`timescale 1ns/100ps
`default_nettype none
module ccw_tick (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic xtal_level,
    output logic      tick
);
    logic prev_reg;
    logic tick_reg;

    // ==========================================================
    // Rising edge of the crystal clock
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= xtal_level;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= xtal_level & ~prev_reg;
        end
    end

    assign tick = tick_reg;
endmodule
`default_nettype wire

//--- logic/ccw_counter.sv
`timescale 1ns/100ps
`default_nettype none
module ccw_counter #(
    parameter int WIDTH = ccw_pkg::CNT_W
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              tick,
    input  wire logic              clear_req,
    input  wire ccw_pkg::ccw_ctrl_t ctrl,
    output logic                   expire
);
    ccw_pkg::ccw_ctrl_t shadow_reg;
    logic [WIDTH-1:0]   count_reg;
    logic               expire_reg;
    logic [WIDTH-1:0]   limit;
    logic               timed;

    // ==========================================================
    // Settings taken over on crystal edges
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shadow_reg <= '{prescale: ccw_pkg::PRE_RST, enable: ccw_pkg::EN_RST};
        end else if (tick) begin
            shadow_reg <= ctrl;
        end
    end

    assign timed = shadow_reg.enable && (shadow_reg.prescale <= ccw_pkg::PRE_MAX_TIMED);
    assign limit = {WIDTH{1'b1}} >> (3'd7 - shadow_reg.prescale[2:0]);

    // ==========================================================
    // Count and expiry
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (tick) begin
            if (clear_req) begin
                count_reg <= '0;
            end else if (timed) begin
                if (count_reg == limit) begin
                    count_reg <= '0;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= tick && !clear_req && timed && (count_reg == limit);
        end
    end

    assign expire = expire_reg;

    // ==========================================================
    // Checks
    AST_EXPIRE_AT_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
        tick && !clear_req && timed && count_reg == limit |=> expire && count_reg == '0)
        else $error("expiry missed at counter limit");
    AST_CLEAR_RESTARTS: assert property (@(posedge mclk) disable iff (!reset_n)
        tick && clear_req |=> count_reg == '0 && !expire)
        else $error("clear did not restart counter");
endmodule
`default_nettype wire

//--- testbench/ccw_xtal_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Crystal source, level synchronous to mclk, stoppable
module ccw_xtal_model #(
    parameter int HALF = 2
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      crystal_in_pin
);
    int half_cnt;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            half_cnt       <= 0;
            crystal_in_pin <= 1'b0;
        end else if (run) begin
            if (half_cnt == HALF - 1) begin
                half_cnt       <= 0;
                crystal_in_pin <= ~crystal_in_pin;
            end else begin
                half_cnt <= half_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_crystal_clocked_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
module tb_crystal_clocked_watchdog;
    logic       mclk;
    logic       reset_n;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_byte_wr;
    logic       sfr_bit_wr;
    logic       sfr_bit_val;
    logic       sfr_rd;
    logic       instr_end;
    logic       crystal_in_pin;
    logic       flash_wdt_prot_bit;
    logic       xtal_run;
    logic [7:0] sfr_rdata;
    logic       sys_reset_req;
    logic       download_reset_req;
    logic       wdt_irq;
    int         error_cnt;
    int         compares;
    int         cyc_no;
    int         n_rst;
    int         n_dl;
    int         n_irq;
    int         t_rst;
    int         t_irq;
    int         t0;
    int         t1;

    // ==========================================================
    // Design and crystal source
    ccw_top dut (
        .mclk               (mclk),
        .reset_n            (reset_n),
        .sfr_addr           (sfr_addr),
        .sfr_wdata          (sfr_wdata),
        .sfr_byte_wr        (sfr_byte_wr),
        .sfr_bit_wr         (sfr_bit_wr),
        .sfr_bit_val        (sfr_bit_val),
        .sfr_rd             (sfr_rd),
        .instr_end          (instr_end),
        .crystal_in_pin     (crystal_in_pin),
        .flash_wdt_prot_bit (flash_wdt_prot_bit),
        .sfr_rdata          (sfr_rdata),
        .sys_reset_req      (sys_reset_req),
        .download_reset_req (download_reset_req),
        .wdt_irq            (wdt_irq)
    );

    ccw_xtal_model #(.HALF(2)) xtal (
        .mclk           (mclk),
        .reset_n        (reset_n),
        .run            (xtal_run),
        .crystal_in_pin (crystal_in_pin)
    );

    // ==========================================================
    // Clock and output pulse monitor
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc_no++;
        if (sys_reset_req === 1'b1) begin
            n_rst++;
            t_rst = cyc_no;
        end
        if (download_reset_req === 1'b1) n_dl++;
        if (wdt_irq === 1'b1) begin
            n_irq++;
            t_irq = cyc_no;
        end
    end

    // ==========================================================
    // Checking and bus tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One instruction: optional byte or bit write, ends with instr_end
    task automatic instr(input logic [7:0] a, input logic [7:0] d, input logic bw,
                         input logic btw, input logic bv);
        sfr_addr    <= a;
        sfr_wdata   <= d;
        sfr_byte_wr <= bw;
        sfr_bit_wr  <= btw;
        sfr_bit_val <= bv;
        instr_end   <= 1'b1;
        @(posedge mclk);
        sfr_byte_wr <= 1'b0;
        sfr_bit_wr  <= 1'b0;
        instr_end   <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic unlock;
        instr(8'hc0, 8'h00, 1'b0, 1'b1, 1'b1);
    endtask

    task automatic wr(input logic [7:0] d);
        unlock();
        instr(8'hc0, d, 1'b1, 1'b0, 1'b0);
        t0 = cyc_no;
    endtask

    task automatic rd(input string name, input logic [7:0] exp);
        sfr_addr <= 8'hc0;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1 check(name, sfr_rdata, exp);
        @(posedge mclk);
    endtask

    task automatic done(input string name);
        $display("Done %s", name);
    endtask

    // ==========================================================
    // Hang guard
    initial begin
        #1000000;
        error_cnt++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        error_cnt = 0; compares = 0; cyc_no = 0;
        n_rst = 0; n_dl = 0; n_irq = 0; t_rst = 0; t_irq = 0; t0 = 0; t1 = 0;
        reset_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_byte_wr = 1'b0;
        sfr_bit_wr = 1'b0; sfr_bit_val = 1'b0; sfr_rd = 1'b0; instr_end = 1'b0;
        flash_wdt_prot_bit = 1'b1; xtal_run = 1'b1;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd("reset_image", 8'h72);
        done("reset");

        instr(8'hc0, 8'h00, 1'b1, 1'b0, 1'b0);
        rd("locked_write", 8'h72);
        unlock();
        instr(8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        instr(8'hc0, 8'h00, 1'b1, 1'b0, 1'b0);
        rd("late_write", 8'h72);
        done("unlock");

        wr(8'h02);
        rd("pre0_image", 8'h02);
        for (int k = 0; k < 3; k++) begin
            repeat (1500) @(posedge mclk);
            unlock();
            instr(8'hc1, 8'h00, 1'b0, 1'b1, 1'b1);
            t0 = cyc_no;
        end
        check("no_reset_kicked", 8'(n_rst), 8'h00);
        repeat (2200) @(posedge mclk);
        check("reset_count", 8'(n_rst), 8'h01);
        check("reset_delay", 8'(t_rst - t0 >= 2040 && t_rst - t0 <= 2090), 8'h01);
        rd("after_wdt_reset", 8'h76);
        done("timeout");

        wr(8'h76);
        rd("flag_write1", 8'h76);
        wr(8'h72);
        rd("flag_write0", 8'h72);
        done("flag");

        wr(8'h00);
        repeat (3000) @(posedge mclk);
        check("disabled", 8'(n_rst + n_irq), 8'h01);
        rd("disabled_image", 8'h00);
        xtal_run <= 1'b0;
        wr(8'h02);
        repeat (3000) @(posedge mclk);
        check("xtal_stopped", 8'(n_rst), 8'h01);
        xtal_run <= 1'b1;
        repeat (2200) @(posedge mclk);
        check("xtal_restart", 8'(n_rst), 8'h02);
        done("disable");

        wr(8'h1a);
        repeat (4300) @(posedge mclk);
        check("irq_first", 8'(n_irq), 8'h01);
        t1 = t_irq;
        repeat (4200) @(posedge mclk);
        check("irq_second", 8'(n_irq), 8'h02);
        check("irq_period", 8'(t_irq - t1 >= 4088 && t_irq - t1 <= 4104), 8'h01);
        check("irq_no_reset", 8'(n_rst), 8'h02);
        rd("irq_image", 8'h1e);
        done("interrupt");

        wr(8'h82);
        repeat (10) @(posedge mclk);
        check("code_auto", 8'(n_rst), 8'h03);
        wr(8'h92);
        repeat (10) @(posedge mclk);
        check("code_download", 8'(n_dl), 8'h01);
        wr(8'ha2);
        repeat (3000) @(posedge mclk);
        check("code_invalid", 8'(n_rst + n_dl + n_irq), 8'h06);
        rd("invalid_image", 8'ha2);
        done("codes");

        flash_wdt_prot_bit <= 1'b0;
        @(posedge mclk);
        rd("prot_image", 8'ha2);
        wr(8'h08);
        rd("prot_locked", 8'h02);
        repeat (2200) @(posedge mclk);
        check("prot_reset", 8'(n_rst), 8'h04);
        check("prot_no_irq", 8'(n_irq), 8'h02);
        flash_wdt_prot_bit <= 1'b1;
        @(posedge mclk);
        rd("unprot_image", 8'h76);
        done("protection");

        print_verdict();
    end
endmodule
`default_nettype wire
